// >>> design/spd_top.sv
// Serial port, load strobe, alert and address pin logic of the converter device.
// Assumes sclk and cs_n come from the host, limit flags and the address phase pulse from clk-domain logic.
`default_nettype none

module spd_top (
  // System clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Serial port pins.
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              din,
  output logic                   dout_o,
  output logic                   dout_oe_n,
  // Load strobe pin.
  input  wire logic              dac_load_strobe_n,
  // Limit comparators and alert pin.
  input  wire spd_pkg::spd_limit_t limit_over,
  output logic                   alert_o,
  output logic                   alert_oe_n,
  // Address select pin and two-wire engine.
  input  wire logic              addr_pin_high,
  input  wire logic              addr_pin_float,
  input  wire logic              twowire_addr_done,
  output logic [6:0]             bus_addr,
  // Converter side.
  output spd_pkg::spd_dac_t      dac_value,
  output logic                   analog_input_three_sel
);
  import spd_pkg::*;

  // ****************************************************************
  // Serial clock domain: reset, frame shift and write commit.
  // ****************************************************************
  logic [1:0]  srst_pipe;
  logic        srst;
  logic [4:0]  bit_cnt;
  logic [14:0] shift_in;
  logic [15:0] wr_word;
  logic        wr_tgl;
  logic        rd_act;
  logic [7:0]  tx_buf;
  logic [7:0]  rd_sel;
  logic [2:0]  cmd_addr;
  logic [1:0]  flag_sync;
  logic        snap_ack;
  spd_snap_t   snap_copy;
  logic        snap_flag;
  spd_snap_t   snap_reg;

  always_ff @(posedge sclk)
  begin
    srst_pipe <= {srst_pipe[0], rst};
  end
  assign srst = srst_pipe[1];

  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt <= 5'h00;
    end
    else
    begin
      shift_in <= {shift_in[13:0], din};
      if (bit_cnt != FRAME_BITS)
      begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge sclk)
  begin
    if (srst)
    begin
      wr_tgl  <= 1'b0;
      wr_word <= 16'h0000;
    end
    else if (!cs_n && bit_cnt == FRAME_BITS - 5'h01 && !shift_in[FRM_RD_POS])
    begin
      wr_word <= {shift_in, din};
      wr_tgl  <= ~wr_tgl;
    end
  end

  assign cmd_addr = {shift_in[1:0], din};

  always_comb
  begin
    rd_sel = 8'h00;
    if (cmd_addr <= REG_IN_LAST)
    begin
      rd_sel = snap_copy.inp[cmd_addr[1:0]];
    end
    else if (cmd_addr == REG_CFG)
    begin
      rd_sel = snap_copy.cfg;
    end
    else if (cmd_addr == REG_STAT)
    begin
      rd_sel = snap_copy.stat;
    end
  end

  always_ff @(posedge sclk)
  begin
    if (srst)
    begin
      rd_act <= 1'b0;
      tx_buf <= 8'h00;
    end
    else if (!cs_n && bit_cnt == CMD_LAST_BIT)
    begin
      rd_act <= shift_in[6];
      tx_buf <= rd_sel;
    end
  end

  // Open-drain data output: a zero pulls low, a one releases.
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      dout_oe_n <= 1'b1;
    end
    else
    begin
      dout_oe_n <= ~(rd_act && bit_cnt >= DATA_FIRST && bit_cnt != FRAME_BITS
                     && !tx_buf[~bit_cnt[2:0]]);
    end
  end

  // Snapshot copy taken from the system domain by toggle handshake.
  always_ff @(posedge sclk)
  begin
    if (srst)
    begin
      flag_sync <= 2'h0;
      snap_ack  <= 1'b0;
      snap_copy <= '0;
    end
    else
    begin
      flag_sync <= {flag_sync[0], snap_flag};
      if (flag_sync[1] != snap_ack)
      begin
        snap_copy <= snap_reg;
        snap_ack  <= flag_sync[1];
      end
    end
  end

  // ****************************************************************
  // System domain: crossings and pin synchronisers.
  // ****************************************************************
  logic [2:0] wr_sync;
  logic       wr_evt;
  logic [1:0] ack_sync;
  logic       snap_busy;
  logic [2:0] ld_sync;
  logic       pin_fall;
  logic [1:0] hi_sync;
  logic [1:0] fl_sync;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_sync  <= 3'h0;
      ack_sync <= 2'h0;
      ld_sync  <= 3'h7;
      hi_sync  <= 2'h0;
      fl_sync  <= 2'h0;
    end
    else
    begin
      wr_sync  <= {wr_sync[1:0], wr_tgl};
      ack_sync <= {ack_sync[0], snap_ack};
      ld_sync  <= {ld_sync[1:0], dac_load_strobe_n};
      hi_sync  <= {hi_sync[0], addr_pin_high};
      fl_sync  <= {fl_sync[0], addr_pin_float};
    end
  end
  assign wr_evt   = wr_sync[2] ^ wr_sync[1];
  assign pin_fall = ld_sync[2] && !ld_sync[1];

  // ****************************************************************
  // Input, configuration and DAC registers.
  // ****************************************************************
  spd_dac_t   inp_reg;
  logic [3:0] new_reg;
  logic [3:0] new_next;
  spd_cfg_t   cfg_reg;
  logic [2:0] wr_addr;
  logic       soft_load;
  logic       load_evt;

  assign wr_addr   = wr_word[10:8];
  assign soft_load = wr_evt && wr_addr == REG_CFG && wr_word[CFG_SOFT_POS]
                     && !wr_word[CFG_LOAD_POS];
  assign load_evt  = (pin_fall && cfg_reg.load_pin_en) || soft_load;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      new_next[i] = (new_reg[i] && !load_evt)
                    || (wr_evt && wr_addr == 3'(i));
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      inp_reg <= '0;
      new_reg <= 4'h0;
    end
    else
    begin
      new_reg <= new_next;
      if (wr_evt && wr_addr <= REG_IN_LAST)
      begin
        inp_reg[wr_addr[1:0]] <= wr_word[7:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_reg                <= CFG_RESET;
      analog_input_three_sel <= ~CFG_RESET[CFG_LOAD_POS];
    end
    else if (wr_evt && wr_addr == REG_CFG)
    begin
      cfg_reg                <= {5'h00, 1'b0, wr_word[CFG_ALERT_POS], wr_word[CFG_LOAD_POS]};
      analog_input_three_sel <= ~wr_word[CFG_LOAD_POS];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dac_value <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (load_evt && new_reg[i])
        begin
          dac_value[i] <= inp_reg[i];
        end
      end
    end
  end

  // Snapshot of the readable registers handed to the serial domain.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      snap_busy <= 1'b0;
      snap_flag <= 1'b0;
      snap_reg  <= '0;
    end
    else if (!snap_busy)
    begin
      snap_reg  <= '{inp: inp_reg, cfg: cfg_reg, stat: {new_reg, 1'b0, limit_over}};
      snap_flag <= ~snap_flag;
      snap_busy <= 1'b1;
    end
    else if (ack_sync[1] == snap_flag)
    begin
      snap_busy <= 1'b0;
    end
  end

  // ****************************************************************
  // Alert pin and bus address.
  // ****************************************************************
  logic       addr_locked;
  logic [1:0] addr_cnt;
  logic [6:0] addr_pin;

  assign addr_pin = hi_sync[1] ? ADDR_HIGH : (fl_sync[1] ? ADDR_FLOAT : ADDR_LOW);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alert_oe_n <= 1'b1;
      alert_o    <= 1'b0;
      dout_o     <= 1'b0;
    end
    else
    begin
      alert_oe_n <= ~((|limit_over) ^ cfg_reg.alert_high);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_locked <= 1'b0;
      addr_cnt    <= 2'h0;
      bus_addr    <= ADDR_LOW;
    end
    else if (!addr_locked)
    begin
      bus_addr <= addr_pin;
      if (twowire_addr_done)
      begin
        addr_cnt    <= addr_cnt + 2'h1;
        addr_locked <= (addr_cnt + 2'h1) == ADDR_LATCH_N;
      end
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  din_sample_a: assert property (@(posedge sclk) disable iff (srst)
    (!cs_n && bit_cnt < FRAME_BITS) |=> (shift_in[0] == $past(din)))
    else $error("Serial input bit not sampled on the rising edge.");

  dout_first_a: assert property (@(posedge sclk) disable iff (srst)
    (!cs_n && rd_act && bit_cnt == DATA_FIRST) |-> (dout_oe_n == tx_buf[7]))
    else $error("First read bit not presented after the falling edge.");

  dout_idle_a: assert property (@(posedge sclk) disable iff (srst)
    (!rd_act && bit_cnt > DATA_FIRST) |-> dout_oe_n)
    else $error("Data output pulled low outside a read.");

  load_copy_a: assert property (@(posedge clk) disable iff (rst)
    (pin_fall && cfg_reg.load_pin_en && new_reg[0]) |=> (dac_value[0] == $past(inp_reg[0])))
    else $error("Load strobe did not copy the input register.");

  load_gate_a: assert property (@(posedge clk) disable iff (rst)
    (pin_fall && !cfg_reg.load_pin_en && !soft_load) |=> $stable(dac_value))
    else $error("Disabled load strobe changed a DAC register.");

  reset_default_a: assert property (@(posedge clk)
    $past(rst) |-> (cfg_reg.load_pin_en && !cfg_reg.alert_high && !analog_input_three_sel))
    else $error("Configuration defaults wrong after reset.");

  alert_level_a: assert property (@(posedge clk) disable iff (rst)
    (|limit_over) |=> (alert_oe_n == $past(cfg_reg.alert_high)))
    else $error("Alert level does not follow the polarity.");

  open_drain_a: assert property (@(posedge clk) disable iff (rst)
    (alert_o == 1'b0) && (dout_o == 1'b0))
    else $error("Open-drain output driven high.");

  addr_pick_a: assert property (@(posedge clk) disable iff (rst)
    (!addr_locked && hi_sync[1]) |=> (bus_addr == ADDR_HIGH))
    else $error("Address does not follow the high pin.");

  addr_hold_a: assert property (@(posedge clk) disable iff (rst)
    addr_locked |=> ($stable(bus_addr) && addr_locked))
    else $error("Latched address changed.");

endmodule

`default_nettype wire

// >>> design/spd_pkg.sv
// Constants and carrier types for the serial port, load strobe, alert and address pin block.
// Assumes a 100 MHz system clock and a serial clock that the host drives only inside frames and while reset is held.
// Behaviour
// - While frame select is low, each input bit is sampled on a rising serial clock edge.
// - Read data leaves on the data output, each bit changing on a falling serial clock edge.
// - A falling load strobe copies every input register holding new data into its DAC register.
// - The load strobe is obeyed only while the load pin enable bit allows it.
// - After reset the load strobe pin controls DAC register loading.
// - Alert asserts on any exceeded limit, with selectable low or high asserted level.
// - After reset the alert output is active low.
// - Alert and data outputs are open drain: pulled low or released, never driven high.
// - Bus address comes from the address pin: low, floating or high.
// - Address latches on the second valid address phase; later pin changes are ignored.
`default_nettype none

package spd_pkg;

  // ****************************************************************
  // Serial frame layout.
  // ****************************************************************
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  localparam logic [4:0] DATA_FIRST   = 5'h08;
  localparam int         FRM_RD_POS   = 14;

  // ****************************************************************
  // Register addresses and configuration fields.
  // ****************************************************************
  localparam logic [2:0] REG_IN_LAST  = 3'h3;
  localparam logic [2:0] REG_CFG      = 3'h4;
  localparam logic [2:0] REG_STAT     = 3'h5;
  localparam int         CFG_LOAD_POS = 0;
  localparam int         CFG_ALERT_POS = 1;
  localparam int         CFG_SOFT_POS = 2;
  localparam logic [7:0] CFG_RESET    = 8'h01;

  // ****************************************************************
  // Two-wire bus addresses and latch count.
  // ****************************************************************
  localparam logic [6:0] ADDR_LOW     = 7'h48;
  localparam logic [6:0] ADDR_FLOAT   = 7'h4A;
  localparam logic [6:0] ADDR_HIGH    = 7'h4B;
  localparam logic [1:0] ADDR_LATCH_N = 2'h2;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************
  typedef logic [3:0][7:0] spd_dac_t;

  typedef struct packed {
    logic [4:0] unused;
    logic       soft_load;
    logic       alert_high;
    logic       load_pin_en;
  } spd_cfg_t;

  typedef struct packed {
    logic temp;
    logic vdd;
    logic ain;
  } spd_limit_t;

  typedef struct packed {
    spd_dac_t   inp;
    spd_cfg_t   cfg;
    logic [7:0] stat;
  } spd_snap_t;

endpackage

`default_nettype wire

// >>> verification/spd_host_model.sv
// Host side of the serial port: frame select, serial clock and data in, read of the open-drain data line.
// Assumes a pull-up on the data line and that the bench calls its tasks one at a time.
`default_nettype none

module spd_host_model (
  // Serial port pins.
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  // Open-drain data output of the device.
  input  wire logic dout_o,
  input  wire logic dout_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Pulled-up data line and idle levels.
  // ****************************************************************
  logic line;

  assign line = dout_oe_n ? 1'b1 : dout_o;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // ****************************************************************
  // Clock pulses with the frame closed, used while reset is held.
  // ****************************************************************
  task automatic pulses(input int n);
    repeat (n)
    begin
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
  endtask

  // ****************************************************************
  // One sixteen bit frame, most significant bit first, clock at 30 ns.
  // ****************************************************************
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    cs_n = 1'b0;
    #15;
    for (int i = 15; i >= 0; i--)
    begin
      din = tx[i];
      #15 sclk = 1'b1;
      if (i < 8)
        rx[i] = line;
      #15 sclk = 1'b0;
    end
    #15 cs_n = 1'b1;
    din = ~din;
    #30;
  endtask
endmodule

`default_nettype wire

// >>> verification/spd_top_bench.sv
// Self-checking bench of the serial port, load strobe, alert and address pin block.
// Assumes the host model drives the link clock only within frames and during reset.
`default_nettype none

module spd_top_bench;
  import spd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk, rst, sclk, cs_n, din, dout_o, dout_oe_n, ldn, alert_o, alert_oe_n;
  logic       ahi, aflt, adone, a3sel;
  logic [6:0] bus_addr;
  logic [7:0] rx;
  spd_limit_t lim;
  spd_dac_t   dac;
  int         error_cnt;
  int         n_checks;

  spd_top dut_u (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o),
    .dout_oe_n(dout_oe_n), .dac_load_strobe_n(ldn), .limit_over(lim), .alert_o(alert_o),
    .alert_oe_n(alert_oe_n), .addr_pin_high(ahi), .addr_pin_float(aflt), .twowire_addr_done(adone),
    .bus_addr(bus_addr), .dac_value(dac), .analog_input_three_sel(a3sel));

  spd_host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n));

  initial
    clk = 1'b0;
  always #5 clk = ~clk;

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host_u.xfer({1'b0, a, d}, r);
    cyc(8);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host_u.xfer({1'b1, a, 8'h00}, d);
    cyc(2);
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset;
    chk({alert_oe_n, dout_oe_n, alert_o, dout_o}, 4'hC);
    chk(bus_addr, ADDR_LOW);
    chk(dac, 32'h0000_0000);
    chk(a3sel, 1'b0);
  endtask

  task automatic t_load;
    for (int i = 0; i <= REG_IN_LAST; i++)
      wr(7'(i), 8'(8'h11 * (i + 1)));
    wr(7'(REG_STAT), 8'hFF);
    rd(7'(REG_STAT), rx);
    chk(rx, 8'hF0);
    ldn = 1'b0;
    cyc(2);
    chk(dac, 32'h0000_0000);
    cyc(1);
    chk(dac, 32'h4433_2211);
    ldn = 1'b1;
    cyc(3);
    rd(7'h02, rx);
    chk(rx, 8'h33);
    rd(7'(REG_STAT), rx);
    chk(rx, 8'h00);
    wr(7'h01, 8'h5A);
    ldn = 1'b0;
    cyc(3);
    ldn = 1'b1;
    cyc(3);
    chk(dac, 32'h4433_5A11);
  endtask

  task automatic t_cfg;
    wr(7'(REG_CFG), 8'h00);
    chk(a3sel, 1'b1);
    wr(7'h00, 8'h77);
    ldn = 1'b0;
    cyc(3);
    ldn = 1'b1;
    cyc(3);
    chk(dac, 32'h4433_5A11);
    wr(7'(REG_CFG), 8'h04);
    chk(dac, 32'h4433_5A77);
    wr(7'(REG_CFG), 8'h01);
    rd(7'(REG_CFG), rx);
    chk({a3sel, rx}, 9'h001);
  endtask

  task automatic t_alert;
    for (int i = 0; i < 3; i++)
    begin
      lim = spd_limit_t'(3'b001 << i);
      cyc(2);
      chk(alert_oe_n, 1'b0);
      lim = '0;
      cyc(2);
      chk(alert_oe_n, 1'b1);
    end
    wr(7'(REG_CFG), 8'h03);
    chk(alert_oe_n, 1'b0);
    lim.vdd = 1'b1;
    cyc(2);
    chk(alert_oe_n, 1'b1);
    lim = '0;
    wr(7'(REG_CFG), 8'h01);
  endtask

  task automatic t_addr;
    aflt = 1'b1;
    cyc(5);
    chk(bus_addr, ADDR_FLOAT);
    ahi = 1'b1;
    cyc(5);
    chk(bus_addr, ADDR_HIGH);
    repeat (2)
    begin
      adone = 1'b1;
      cyc(1);
      adone = 1'b0;
      cyc(3);
    end
    ahi  = 1'b0;
    aflt = 1'b0;
    cyc(6);
    chk(bus_addr, ADDR_HIGH);
  endtask

  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  initial
  begin
    rst       = 1'b1;
    ldn       = 1'b1;
    lim       = '0;
    ahi       = 1'b0;
    aflt      = 1'b0;
    adone     = 1'b0;
    error_cnt = 0;
    n_checks  = 0;
    fork
      host_u.pulses(3);
      cyc(6);
    join
    rst = 1'b0;
    cyc(5);
    t_reset();
    t_load();
    t_cfg();
    t_alert();
    t_addr();
    close_out();
  end

  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule

`default_nettype wire
